// ==== rtl/ahp_device.sv ====
// converter side of the parallel port: pins, control words, result stream
`timescale 1ns/1ps
// Behaviour
// - respond only with both selects asserted
// - twelve data lines, line 0 is LSB
// - lines 11:10 address the control word
// - write pin: r/w select or write strobe
// - read strobe honoured only in write-only mode
// - marker shows channel A data on bus
// - host's first access must be a write
// - reference source chosen by control word 0
// - host supplies the conversion clock
// - new conversion on each conversion clock fall
// - result on bus five conversion clocks later
// - marker low for channel A, else high
// - marker disabled in single channel mode
module ahp_device (
  input wire logic ref_clk_i, // 100 MHz clock
  input wire logic reset_i, // sync reset, high
  input wire logic ce_i, // clock enable
  ahp_if.device link, // pins to the host
  input wire logic [ahp_pkg::NUM_CH*ahp_pkg::DATA_W-1:0] chan_data_i, // channel values
  output logic ref_external_o, // external reference chosen
  output logic [ahp_pkg::CH_W-1:0] chan_count_o, // channels minus one
  output logic write_only_o, // write pin is a strobe
  output logic initialized_o // first write seen
);
  localparam int PW = ahp_pkg::DEV_PIN_W;
  localparam int DW = ahp_pkg::DATA_W;
  localparam int CW = ahp_pkg::CH_W;
  localparam int LAT = ahp_pkg::PIPE_LAT;

  typedef struct packed {
    logic [PW-1:0] s1;
    logic [PW-1:0] s2;
    logic [PW-1:0] s3;
    logic [PW-1:0] filt;
    logic [ahp_pkg::VAL_W-1:0] cr0;
    logic [ahp_pkg::VAL_W-1:0] cr1;
    logic init;
    logic [CW-1:0] scan;
    logic [ahp_pkg::NUM_CH*DW-1:0] hold;
    logic [LAT-1:0][CW+DW-1:0] pipe;
    logic wr_prev;
    logic [DW-1:0] wlat;
    logic [DW-1:0] bus_d;
    logic bus_oe;
    logic sync_n;
  } ahp_dev_state_t;

  ahp_dev_state_t r;
  ahp_dev_state_t n;
  logic [PW-1:0] pins;
  logic [PW-1:0] filt_nx;

  // gather the pins into one vector
  assign pins = {link.data_bus, link.read_strobe_n, link.write_pin,
                 link.select_high_active, link.select_low_active_n, link.conversion_clock_in};

  // per pin: take a change once stages two and three agree
  for (genvar i = 0; i < PW; i++) begin : g_filt
    assign filt_nx[i] = (r.s2[i] == r.s3[i]) ? r.s3[i] : r.filt[i];
  end

  // next state
  always_comb begin
    logic conv_fall;
    logic sel;
    logic wo;
    logic wr_act;
    logic rd_act;
    logic multi;
    logic [CW-1:0] nch;
    logic [DW-1:0] word;
    logic [DW-1:0] din;
    conv_fall = 1'b0;
    sel = 1'b0;
    wo = 1'b0;
    wr_act = 1'b0;
    rd_act = 1'b0;
    multi = 1'b0;
    nch = '0;
    word = '0;
    din = '0;
    n = r;
    n.s1 = pins;
    n.s2 = r.s1;
    n.s3 = r.s2;
    n.filt = filt_nx;
    din = filt_nx[ahp_pkg::PIN_DATA +: DW];
    conv_fall = r.filt[ahp_pkg::PIN_CONV] & ~filt_nx[ahp_pkg::PIN_CONV];
    sel = ~filt_nx[ahp_pkg::PIN_SEL_N] & filt_nx[ahp_pkg::PIN_SEL];
    wo = r.cr1[ahp_pkg::CR1_WO_BIT];
    // low write pin means write in both modes
    wr_act = sel & ~filt_nx[ahp_pkg::PIN_WRP];
    rd_act = sel & (wo ? ~filt_nx[ahp_pkg::PIN_RD_N] : filt_nx[ahp_pkg::PIN_WRP]);
    nch = r.cr0[ahp_pkg::CR0_NCH_LSB +: CW];
    multi = (nch != '0);

    // write: hold the word, take it as the write ends
    n.wr_prev = wr_act;
    if (wr_act) begin
      n.wlat = din;
    end
    if (r.wr_prev && !wr_act) begin
      n.init = 1'b1;
      case (r.wlat[ahp_pkg::ADDR_MSB:ahp_pkg::ADDR_LSB])
        ahp_pkg::CR0_ADDR: begin
          n.cr0 = r.wlat[ahp_pkg::VAL_W-1:0];
        end
        ahp_pkg::CR1_ADDR: begin
          n.cr1 = r.wlat[ahp_pkg::VAL_W-1:0];
        end
        default: begin
          n.cr0 = r.cr0;
        end
      endcase
    end

    // conversion stream, one word per falling edge
    if (conv_fall) begin
      if (r.scan == '0) begin
        n.hold = chan_data_i; // all channels sampled at once
        word = chan_data_i[DW-1:0];
      end else begin
        word = r.hold[DW*r.scan +: DW];
      end
      n.pipe = {r.pipe[LAT-2:0], {r.scan, word}};
      n.scan = (r.scan >= nch) ? '0 : r.scan + 1'b1;
      // oldest stage is five falls old when loaded here
      n.bus_d = r.pipe[LAT-1][DW-1:0];
      // channel A marker only in multichannel mode
      n.sync_n = ~multi | (r.pipe[LAT-1][DW +: CW] != '0);
    end
    if (!multi) begin
      n.sync_n = 1'b1;
    end

    // data lines driven only inside a selected read
    n.bus_oe = rd_act & r.init;
  end

  // state register
  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      r <= '0;
      r.cr0 <= ahp_pkg::CR_RESET;
      r.cr1 <= ahp_pkg::CR_RESET;
      r.sync_n <= 1'b1;
    end else if (ce_i) begin
      r <= n;
    end
  end

  // pins and user outputs straight from the register
  assign link.dev_d = r.bus_d;
  assign link.dev_oe = r.bus_oe;
  assign link.sync_marker_n = r.sync_n;
  assign ref_external_o = r.cr0[ahp_pkg::CR0_REF_EXT_BIT];
  assign chan_count_o = r.cr0[ahp_pkg::CR0_NCH_LSB +: CW];
  assign write_only_o = r.cr1[ahp_pkg::CR1_WO_BIT];
  assign initialized_o = r.init;
endmodule

// ==== rtl/ahp_fifo.sv ====
// fifo with registered output stage
`timescale 1ns/1ps
module ahp_fifo #(
  parameter int WIDTH = 13,
  parameter int DEPTH = 32
) (
  input wire logic ref_clk_i, // clock
  input wire logic reset_i, // sync reset
  input wire logic ce_i, // clock enable
  input wire logic in_valid_i, // write request
  output logic in_ready_o, // room left
  input wire logic [WIDTH-1:0] in_data_i, // write word
  output logic out_valid_o, // word available
  input wire logic out_ready_i, // reader takes word
  output logic [WIDTH-1:0] out_data_o // read word
);
  localparam int AW = $clog2(DEPTH);
  localparam logic [AW:0] FULL_CNT = (AW + 1)'(DEPTH);

  typedef struct packed {
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [AW:0] cnt;
    logic ov;
    logic [WIDTH-1:0] od;
  } ahp_fifo_state_t;

  ahp_fifo_state_t r;
  ahp_fifo_state_t n;
  logic [WIDTH-1:0] mem [DEPTH];
  logic do_push;
  logic do_pop;

  // handshakes
  assign in_ready_o = (r.cnt != FULL_CNT);
  assign do_push = in_valid_i & in_ready_o;
  assign do_pop = (r.cnt != '0) & (~r.ov | out_ready_i);
  assign out_valid_o = r.ov;
  assign out_data_o = r.od;

  // pointers, count and output stage
  always_comb begin
    n = r;
    if (do_push) begin
      n.wp = r.wp + 1'b1;
    end
    if (do_pop) begin
      n.rp = r.rp + 1'b1;
      n.od = mem[r.rp];
      n.ov = 1'b1;
    end else if (out_ready_i) begin
      n.ov = 1'b0;
    end
    n.cnt = r.cnt + (AW + 1)'(do_push) - (AW + 1)'(do_pop);
  end

  // state register
  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      r <= '0;
    end else if (ce_i) begin
      r <= n;
    end
  end

  // storage
  always_ff @(posedge ref_clk_i) begin
    if (ce_i && do_push) begin
      mem[r.wp] <= in_data_i;
    end
  end
endmodule

// ==== rtl/ahp_host.sv ====
// bus master end: makes the conversion clock, writes control, reads results
//
// The placing of the registers and the plain strobed port were chosen for this implementation.
`timescale 1ns/1ps
module ahp_host (
  input wire logic ref_clk_i, // 100 MHz clock
  input wire logic reset_i, // sync reset, high
  input wire logic ce_i, // clock enable
  ahp_if.host link, // pins to the converter
  input wire logic [ahp_pkg::CMD_AW-1:0] addr_i, // command address
  input wire logic [ahp_pkg::CMD_DW-1:0] wdata_i, // command write data
  input wire logic wr_i, // command write strobe
  input wire logic rd_i, // command read strobe
  output logic [ahp_pkg::CMD_DW-1:0] rdata_o, // command read data
  output logic [ahp_pkg::STREAM_W-1:0] stream_data_o, // {marker_n, result}
  output logic stream_valid_o, // result available
  input wire logic stream_ready_i // result taken
);
  localparam int HW = ahp_pkg::HOST_PIN_W;
  localparam int DW = ahp_pkg::DATA_W;

  typedef struct packed {
    logic [HW-1:0] s1;
    logic [HW-1:0] s2;
    logic [HW-1:0] s3;
    logic [HW-1:0] filt;
    logic [ahp_pkg::CNT_W-1:0] cnt;
    logic conv;
    logic sel_n;
    logic sel;
    logic wrp;
    logic rd_n;
    logic [DW-1:0] dout;
    logic doe;
    logic run;
    logic wo;
    logic init;
    logic pend;
    logic [DW-1:0] pword;
    ahp_pkg::ahp_slot_t slot;
    logic [ahp_pkg::CMD_DW-1:0] rdata;
    logic push;
    logic [ahp_pkg::STREAM_W-1:0] pdata;
  } ahp_host_state_t;

  ahp_host_state_t r;
  ahp_host_state_t n;
  logic [HW-1:0] pins;
  logic [HW-1:0] filt_nx;
  logic fifo_ready;

  assign pins = {link.sync_marker_n, link.data_bus};

  // per pin: take a change once stages two and three agree
  for (genvar i = 0; i < HW; i++) begin : g_filt
    assign filt_nx[i] = (r.s2[i] == r.s3[i]) ? r.s3[i] : r.filt[i];
  end

  // next state
  always_comb begin
    n = r;
    n.s1 = pins;
    n.s2 = r.s1;
    n.s3 = r.s2;
    n.filt = filt_nx;
    n.push = 1'b0;

    // free-running conversion clock, falls at count zero
    n.cnt = (r.cnt == ahp_pkg::CNT_LAST) ? ahp_pkg::CNT_ZERO : r.cnt + 1'b1;
    if (n.cnt == ahp_pkg::CNT_ZERO) begin
      n.conv = 1'b0;
    end else if (n.cnt == ahp_pkg::CNT_HALF) begin
      n.conv = 1'b1;
    end

    // one bus slot per conversion period, inside the two falls
    case (r.slot)
      ahp_pkg::AHP_IDLE: begin
        if (r.cnt == ahp_pkg::SLOT_START) begin
          if (r.pend) begin
            n.slot = ahp_pkg::AHP_WRITE;
            n.sel_n = 1'b0;
            n.sel = 1'b1;
            n.wrp = 1'b0;
            n.dout = r.pword;
            n.doe = 1'b1;
          end else if (r.run && r.init && fifo_ready) begin
            n.slot = ahp_pkg::AHP_READ;
            n.sel_n = 1'b0;
            n.sel = 1'b1;
            n.wrp = 1'b1;
            n.rd_n = ~r.wo;
          end
        end
      end
      ahp_pkg::AHP_READ: begin
        if (r.cnt == ahp_pkg::SLOT_END) begin
          n.push = 1'b1;
          n.pdata = r.filt;
          n.sel_n = 1'b1;
          n.sel = 1'b0;
          n.rd_n = 1'b1;
          n.slot = ahp_pkg::AHP_IDLE;
        end
      end
      ahp_pkg::AHP_WRITE: begin
        if (r.cnt == ahp_pkg::SLOT_END) begin
          // strobe rises in write-only mode, else selects drop
          if (r.wo) begin
            n.wrp = 1'b1;
          end else begin
            n.sel_n = 1'b1;
            n.sel = 1'b0;
          end
        end else if (r.cnt == ahp_pkg::SLOT_RELEASE) begin
          n.sel_n = 1'b1;
          n.sel = 1'b0;
          n.wrp = 1'b1;
          n.doe = 1'b0;
          n.pend = 1'b0;
          n.init = 1'b1;
          if (r.pword[ahp_pkg::ADDR_MSB:ahp_pkg::ADDR_LSB] == ahp_pkg::CR1_ADDR) begin
            n.wo = r.pword[ahp_pkg::CR1_WO_BIT];
          end
          n.slot = ahp_pkg::AHP_IDLE;
        end
      end
      default: begin
        n.slot = ahp_pkg::AHP_IDLE;
      end
    endcase

    // command writes; a new control word is dropped while one is pending
    if (wr_i) begin
      if (addr_i == ahp_pkg::ADR_CTRL) begin
        n.run = wdata_i[ahp_pkg::CTRL_RUN_BIT];
      end else if (addr_i == ahp_pkg::ADR_WRITE && !r.pend) begin
        n.pend = 1'b1;
        n.pword = wdata_i[DW-1:0];
      end
    end

    // command reads, answered next cycle
    if (rd_i) begin
      n.rdata = '0;
      if (addr_i == ahp_pkg::ADR_CTRL) begin
        n.rdata[ahp_pkg::CTRL_RUN_BIT] = r.run;
      end else if (addr_i == ahp_pkg::ADR_STATUS) begin
        n.rdata[ahp_pkg::ST_INIT_BIT] = r.init;
        n.rdata[ahp_pkg::ST_PEND_BIT] = r.pend;
        n.rdata[ahp_pkg::ST_WO_BIT] = r.wo;
        n.rdata[ahp_pkg::ST_RUN_BIT] = r.run;
        n.rdata[ahp_pkg::ST_FULL_BIT] = ~fifo_ready;
      end
    end
  end

  // state register
  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      r <= '0;
      r.conv <= 1'b1;
      r.sel_n <= 1'b1;
      r.wrp <= 1'b1;
      r.rd_n <= 1'b1;
      r.slot <= ahp_pkg::AHP_IDLE;
    end else if (ce_i) begin
      r <= n;
    end
  end

  // results buffered toward the user; full fifo stalls read slots
  ahp_fifo #(
    .WIDTH(ahp_pkg::STREAM_W),
    .DEPTH(ahp_pkg::FIFO_DEPTH)
  ) u_fifo (
    .ref_clk_i(ref_clk_i),
    .reset_i(reset_i),
    .ce_i(ce_i),
    .in_valid_i(r.push),
    .in_ready_o(fifo_ready),
    .in_data_i(r.pdata),
    .out_valid_o(stream_valid_o),
    .out_ready_i(stream_ready_i),
    .out_data_o(stream_data_o)
  );

  // pins from the register
  assign link.conversion_clock_in = r.conv;
  assign link.select_low_active_n = r.sel_n;
  assign link.select_high_active = r.sel;
  assign link.write_pin = r.wrp;
  assign link.read_strobe_n = r.rd_n;
  assign link.host_d = r.dout;
  assign link.host_oe = r.doe;
  assign rdata_o = r.rdata;
endmodule

// ==== shared/ahp_if.sv ====
// pins between converter port and bus master
`timescale 1ns/1ps
interface ahp_if;
  logic conversion_clock_in; // conversion_clock_in
  logic select_low_active_n; // active-low select
  logic select_high_active; // active-high select
  logic write_pin; // r/w select or write strobe (low)
  logic read_strobe_n; // read strobe, write-only mode
  logic [ahp_pkg::DATA_W-1:0] host_d; // host data out
  logic host_oe; // host drives data
  logic [ahp_pkg::DATA_W-1:0] dev_d; // device data out
  logic dev_oe; // device drives data
  logic sync_marker_n; // channel A marker, low active
  logic [ahp_pkg::DATA_W-1:0] data_bus; // resolved level

  // resolved bus, pulled up when idle
  assign data_bus = dev_oe ? dev_d : (host_oe ? host_d : '1);

  modport device (
    input conversion_clock_in, select_low_active_n, select_high_active, write_pin,
    input read_strobe_n, data_bus,
    output dev_d, dev_oe, sync_marker_n
  );
  modport host (
    output conversion_clock_in, select_low_active_n, select_high_active, write_pin,
    output read_strobe_n, host_d, host_oe,
    input data_bus, sync_marker_n
  );
endinterface

// ==== shared/ahp_pkg.sv ====
// constants, field layouts and timing for the parallel converter port
package ahp_pkg;
  // data bus and control word layout
  localparam int DATA_W = 12;
  localparam int VAL_W = 10;
  localparam int ADDR_LSB = 10;
  localparam int ADDR_MSB = 11;
  localparam int NUM_CH = 4;
  localparam int CH_W = 2;
  localparam int PIPE_LAT = 5;
  localparam logic [1:0] CR0_ADDR = 2'h0;
  localparam logic [1:0] CR1_ADDR = 2'h1;
  localparam int CR0_REF_EXT_BIT = 0;
  localparam int CR0_NCH_LSB = 1;
  localparam int CR1_WO_BIT = 0;
  localparam logic [VAL_W-1:0] CR_RESET = 10'h000;
  // device pin vector layout
  localparam int PIN_CONV = 0;
  localparam int PIN_SEL_N = 1;
  localparam int PIN_SEL = 2;
  localparam int PIN_WRP = 3;
  localparam int PIN_RD_N = 4;
  localparam int PIN_DATA = 5;
  localparam int DEV_PIN_W = PIN_DATA + DATA_W;
  // host pin vector layout
  localparam int HOST_SYNC_BIT = DATA_W;
  localparam int HOST_PIN_W = DATA_W + 1;
  localparam int STREAM_W = DATA_W + 1;
  localparam int FIFO_DEPTH = 32;
  // conversion clock made by the host
  localparam int CLK_PERIOD_NS = 10;
  localparam int CONV_PERIOD_NS = 320;
  localparam int CONV_CYCLES = CONV_PERIOD_NS / CLK_PERIOD_NS;
  localparam int CNT_W = $clog2(CONV_CYCLES);
  localparam logic [CNT_W-1:0] CNT_LAST = CNT_W'(CONV_CYCLES - 1);
  localparam logic [CNT_W-1:0] CNT_HALF = CNT_W'(CONV_CYCLES / 2);
  localparam logic [CNT_W-1:0] CNT_ZERO = CNT_W'(0);
  localparam logic [CNT_W-1:0] SLOT_START = CNT_W'(4);
  localparam logic [CNT_W-1:0] SLOT_END = CNT_W'(20);
  localparam logic [CNT_W-1:0] SLOT_RELEASE = CNT_W'(22);
  // host command registers
  localparam int CMD_AW = 4;
  localparam int CMD_DW = 32;
  localparam logic [CMD_AW-1:0] ADR_CTRL = 4'h0;
  localparam logic [CMD_AW-1:0] ADR_WRITE = 4'h4;
  localparam logic [CMD_AW-1:0] ADR_STATUS = 4'h8;
  localparam int CTRL_RUN_BIT = 0;
  localparam int ST_INIT_BIT = 0;
  localparam int ST_PEND_BIT = 1;
  localparam int ST_WO_BIT = 2;
  localparam int ST_RUN_BIT = 3;
  localparam int ST_FULL_BIT = 4;
  // host bus slot states
  typedef enum logic [1:0] {
    AHP_IDLE = 2'b00,
    AHP_READ = 2'b01,
    AHP_WRITE = 2'b10
  } ahp_slot_t;
endpackage

// ==== sim/adc_parallel_host_port_test.sv ====
// self-checking bench for the converter port pair
`timescale 1ns/1ps
module adc_parallel_host_port_test;
  logic ref_clk_i = 1'b0;
  logic reset_i = 1'b1;
  logic [3:0] addr = 4'h0;
  logic [31:0] wdata = 32'h0;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic sready = 1'b0;
  logic [47:0] chan = 48'h0;
  logic [31:0] rdata;
  logic [12:0] sdata;
  logic svalid, ref_ext, wo, init;
  logic [1:0] nch_o;
  int seed = 40;
  int failures = 0;
  int samples_checked = 0;
  ahp_if u_ahp_if ();
  ahp_if u_bad_if ();
  // design pair, plus a lone device facing the bench
  ahp_host u_ahp_host (.ref_clk_i(ref_clk_i), .reset_i(reset_i), .ce_i(1'b1), .link(u_ahp_if),
    .addr_i(addr), .wdata_i(wdata), .wr_i(wr), .rd_i(rd), .rdata_o(rdata),
    .stream_data_o(sdata), .stream_valid_o(svalid), .stream_ready_i(sready));
  ahp_device u_ahp_device (.ref_clk_i(ref_clk_i), .reset_i(reset_i), .ce_i(1'b1),
    .link(u_ahp_if), .chan_data_i(chan), .ref_external_o(ref_ext), .chan_count_o(nch_o),
    .write_only_o(wo), .initialized_o(init));
  ahp_device u_ahp_device_b (.ref_clk_i(ref_clk_i), .reset_i(reset_i), .ce_i(1'b1),
    .link(u_bad_if), .chan_data_i(chan), .ref_external_o(), .chan_count_o(),
    .write_only_o(), .initialized_o());
  ahp_props u_ahp_props (.ref_clk_i(ref_clk_i), .reset_i(reset_i),
    .conversion_clock_in(u_ahp_if.conversion_clock_in), .select_low_active_n(u_ahp_if.select_low_active_n),
    .select_high_active(u_ahp_if.select_high_active), .write_pin(u_ahp_if.write_pin),
    .read_strobe_n(u_ahp_if.read_strobe_n), .host_oe(u_ahp_if.host_oe),
    .dev_d(u_ahp_if.dev_d), .dev_oe(u_ahp_if.dev_oe), .sync_marker_n(u_ahp_if.sync_marker_n));
  // clock
  initial begin
    forever #5 ref_clk_i = ~ref_clk_i;
  end
  // lone device: idle pins, conversion clock copied from the pair
  initial begin
    u_bad_if.select_low_active_n = 1'b1;
    u_bad_if.select_high_active = 1'b0;
    u_bad_if.write_pin = 1'b1;
    u_bad_if.read_strobe_n = 1'b1;
    u_bad_if.host_oe = 1'b0;
    u_bad_if.host_d = 12'h000;
    u_bad_if.conversion_clock_in = 1'b1;
  end
  always @(posedge ref_clk_i) u_bad_if.conversion_clock_in <= u_ahp_if.conversion_clock_in;
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      failures++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic give_verdict();
    $display("checks=%0d mismatches=%0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  task automatic hang();
    failures++;
    give_verdict();
  endtask
  task automatic cmd_wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge ref_clk_i);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge ref_clk_i);
    wr <= 1'b0;
  endtask
  task automatic cmd_rd(input logic [3:0] a, output logic [31:0] d);
    @(posedge ref_clk_i);
    addr <= a;
    rd <= 1'b1;
    @(posedge ref_clk_i);
    rd <= 1'b0;
    #1 d = rdata;
  endtask
  // posts a control word, tries a refused second post, waits for completion
  task automatic dev_write(input logic [1:0] ra, input logic [9:0] v);
    logic [31:0] st;
    int n;
    cmd_wr(ahp_pkg::ADR_WRITE, {20'h0, ra, v});
    cmd_wr(ahp_pkg::ADR_WRITE, {20'h0, ra, ~v});
    st = 32'h2;
    for (n = 0; st[ahp_pkg::ST_PEND_BIT] !== 1'b0; n++) begin
      if (n > 100) hang();
      cmd_rd(ahp_pkg::ADR_STATUS, st);
    end
    repeat (8) @(posedge ref_clk_i);
  endtask
  task automatic take(output logic [12:0] w);
    int i;
    for (i = 0; i < 200; i++) begin
      @(negedge ref_clk_i);
      if (svalid === 1'b1) break;
    end
    if (i == 200) hang();
    w = sdata;
    @(posedge ref_clk_i);
  endtask
  // far side stalls at random until the stream stays empty
  task automatic drain(output int cnt);
    int idle;
    cnt = 0;
    idle = 0;
    for (int i = 0; i < 6000 && idle < 80; i++) begin
      @(negedge ref_clk_i);
      idle = (svalid === 1'b1) ? 0 : idle + 1;
      if (svalid === 1'b1 && sready === 1'b1) cnt++;
      @(posedge ref_clk_i);
      sready <= 1'($random(seed));
    end
  endtask
  function automatic logic [12:0] expect_word(input logic [1:0] c, input logic [1:0] n);
    return {n == 2'h0 || c != 2'h0, chan[c*12 +: 12]};
  endfunction
  task automatic phase(input logic rb, input logic [1:0] n, input logic wm);
    logic [12:0] w;
    logic [1:0] ch;
    int i;
    cmd_wr(ahp_pkg::ADR_CTRL, 32'h0);
    drain(i);
    chan <= {16'($random(seed)), 32'($random(seed))};
    dev_write(ahp_pkg::CR0_ADDR, {7'h00, n, rb});
    dev_write(ahp_pkg::CR1_ADDR, {9'h000, wm});
    check(ref_ext, rb);
    check(nch_o, n);
    check(wo, wm);
    cmd_wr(ahp_pkg::ADR_CTRL, 32'h1);
    sready <= 1'b1;
    for (i = 0; i < 12 && !(i >= 8 && (w[12] === 1'b0 || n == 2'h0)); i++) take(w);
    ch = 2'h0;
    for (i = 0; i < 8; i++) begin
      check(w, expect_word(ch, n));
      ch = (ch == n) ? 2'h0 : ch + 2'h1;
      take(w);
    end
    $display("stream test channels=%0d write_only=%0d done", n + 1, wm);
  endtask
  // main sequence
  initial begin
    logic [31:0] st;
    int n;
    repeat (3) @(posedge ref_clk_i);
    reset_i <= 1'b0;
    @(posedge ref_clk_i);
    u_bad_if.select_low_active_n <= 1'b0;
    u_bad_if.select_high_active <= 1'b1;
    for (n = 0; n < 24; n++) begin
      @(negedge ref_clk_i);
      check({u_bad_if.dev_oe, u_bad_if.data_bus}, 13'h0FFF);
    end
    u_bad_if.select_low_active_n <= 1'b1;
    u_bad_if.select_high_active <= 1'b0;
    cmd_rd(ahp_pkg::ADR_STATUS, st);
    check(st, 32'h0);
    cmd_rd(4'hC, st);
    check(st, 32'h0);
    check(init, 1'b0);
    dev_write(2'h2, 10'h3FF);
    check({init, nch_o, ref_ext}, 4'h8);
    $display("first access test done");
    phase(1'b1, 2'h3, 1'b0);
    phase(1'b0, 2'h1, 1'b1);
    phase(1'($random(seed)), 2'h0, 1'b0);
    phase(1'b1, 2'h2, 1'b1);
    cmd_wr(ahp_pkg::ADR_CTRL, 32'h1);
    sready <= 1'b0;
    st = 32'h0;
    for (n = 0; st[ahp_pkg::ST_FULL_BIT] !== 1'b1; n++) begin
      if (n > 1500) hang();
      cmd_rd(ahp_pkg::ADR_STATUS, st);
    end
    check(st[4:0], 5'h1D);
    cmd_wr(ahp_pkg::ADR_CTRL, 32'h0);
    drain(n);
    check(n >= 32, 1'b1);
    cmd_rd(ahp_pkg::ADR_STATUS, st);
    check(st[ahp_pkg::ST_FULL_BIT], 1'b0);
    $display("buffer test done");
    give_verdict();
  end
endmodule

// ==== sim/ahp_props.sv ====
// link checker for the converter port pair
`timescale 1ns/1ps
module ahp_props (
  input wire logic ref_clk_i, // clock
  input wire logic reset_i, // sync reset
  input wire logic conversion_clock_in, // conversion clock
  input wire logic select_low_active_n, // low select
  input wire logic select_high_active, // high select
  input wire logic write_pin, // write pin
  input wire logic read_strobe_n, // read strobe
  input wire logic host_oe, // host drives bus
  input wire logic [ahp_pkg::DATA_W-1:0] dev_d, // device data
  input wire logic dev_oe, // device drives bus
  input wire logic sync_marker_n // channel A marker
);
  logic sel_on;
  logic conv_q;
  logic seen_q;
  logic any_q;
  logic [4:0] half_q;
  default clocking cb @(posedge ref_clk_i);
  endclocking
  default disable iff (reset_i);
  // both selects asserted
  assign sel_on = !select_low_active_n && select_high_active;
  // half period count and first access tracking
  always_ff @(posedge ref_clk_i) begin
    conv_q <= conversion_clock_in;
    if (reset_i) begin
      half_q <= 5'h00;
      seen_q <= 1'b0;
      any_q <= 1'b0;
    end else begin
      half_q <= (conversion_clock_in != conv_q) ? 5'h00 : half_q + 5'h01;
      seen_q <= seen_q || (conversion_clock_in != conv_q);
      any_q <= any_q || sel_on;
    end
  end
  sequence s_idle8;
    !sel_on [*8];
  endsequence
  sequence s_write8;
    (sel_on && !write_pin) [*8];
  endsequence
  sequence s_high2;
    conversion_clock_in ##1 conversion_clock_in;
  endsequence
  property p_conv_half;
    (conversion_clock_in != conv_q) && seen_q |-> half_q == 5'h0F;
  endproperty
  a_conv_half: assert property (p_conv_half) else $error("conv clock half period wrong");
  property p_no_fight;
    !(dev_oe && host_oe);
  endproperty
  a_no_fight: assert property (p_no_fight) else $error("both ends drive the bus");
  property p_idle_quiet;
    s_idle8 |-> !dev_oe;
  endproperty
  a_idle_quiet: assert property (p_idle_quiet) else $error("device drives unselected");
  property p_write_quiet;
    s_write8 |-> !dev_oe;
  endproperty
  a_write_quiet: assert property (p_write_quiet) else $error("device drives in write");
  property p_data_step;
    $changed(dev_d) |-> !conversion_clock_in;
  endproperty
  a_data_step: assert property (p_data_step) else $error("data moved off clock low");
  property p_marker_hold;
    $fell(sync_marker_n) |=> !sync_marker_n [*8];
  endproperty
  a_marker_hold: assert property (p_marker_hold) else $error("marker pulse too short");
  property p_slot_open;
    $rose(sel_on) |-> !conversion_clock_in && !$past(conversion_clock_in);
  endproperty
  a_slot_open: assert property (p_slot_open) else $error("select before clock low");
  property p_slot_close;
    $fell(sel_on) |-> s_high2;
  endproperty
  a_slot_close: assert property (p_slot_close) else $error("select ends too late");
  property p_first_write;
    sel_on && !any_q |-> !write_pin;
  endproperty
  a_first_write: assert property (p_first_write) else $error("first access not a write");
  property p_strobe_mode;
    sel_on && !read_strobe_n |-> write_pin;
  endproperty
  a_strobe_mode: assert property (p_strobe_mode) else $error("read strobe with write low");
endmodule
